/* dcrp_map.vh */
// Purpose: constants for the converter code, reset and power-down core
// Assumes: plain Verilog-2005, included by bare name
// Notes: code and counter widths and the core's codes live here
`ifndef DCRP_MAP_VH
`define DCRP_MAP_VH
`define DCRP_CODE_W      16
`define DCRP_CNT_W       5
`define DCRP_FRAME_BITS  5'h10
`define DCRP_ZERO_CODE   16'h0000
`define DCRP_MID_CODE    16'h8000
`define DCRP_MSB         15
`define DCRP_GAIN_ONE    2'h1
`define DCRP_GAIN_TWO    2'h2
`endif

/* dcrp_sync.v */
// Purpose: two-flop synchroniser for an input from outside the core clock
// Assumes: input is a level or slow edge relative to core_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module dcrp_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire core_clk,
    input  wire arst_n,
    input  wire async_in,
    output reg  sync_ff
);
    reg meta_ff;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
endmodule // dcrp_sync

/* dcrp_core.v */
// Purpose: digital core of a 16-bit voltage-output converter
// Assumes: serial clock slower than half of CORE_CLK; straps are static levels
// Notes: pins are oversampled by CORE_CLK; serial edges found from synced levels
`timescale 1ns/1ps
`include "dcrp_map.vh"

// Operation
// [R1] each code arrives as one 16-bit serial word
// [R2] format strap high: straight binary code drives the converter
// [R3] format strap low: twos complement, 8000h zero-scale, 0000h midscale
// [R4] converter code spans 0 to 65535; step is span over 65536 times gain
// [R5] gain strap low gives gain 1, high gives gain 2
// [R6] reset pin low holds input register and latch at reset-level value
// [R7] reset pin high resumes serial writes and load strobes
// [R8] power-up sets registers and output to reset-level value
// [R9] reset value is 0000h for strap low, 8000h for strap high
// [R10] host must not use load strobe in twos complement before valid write
// [R11] power-down pin high grounds the analog output
// [R12] power-down leaves input register and latch unchanged
// [R13] serial interface keeps working during power-down
// [R14] data shifts on rising serial clock while select low; last 16 kept
// [R15] frames under 16 bits are discarded
// [R16] select rising after valid frame copies shift register to input register
// [R17] latch holds while load strobe high, transparent while low
// [R18] twos complement inverts the code msb to form offset binary
// [R19] hardware reset pin is synchronised before use
module dcrp_core (
    input  wire                    CORE_CLK,
    input  wire                    ARST_N,
    input  wire                    RESET_N_PIN,
    input  wire                    SCLK_PIN,
    input  wire                    CS_N_PIN,
    input  wire                    DIN_PIN,
    input  wire                    LOAD_OUTPUT_N,
    input  wire                    POWER_DOWN_PIN,
    input  wire                    CODE_FORMAT_SELECT,
    input  wire                    RESET_LEVEL_SELECT,
    input  wire                    GAIN_SELECT,
    output reg  [`DCRP_CODE_W-1:0] CONV_CODE,
    output reg  [1:0]              BUFFER_GAIN,
    output reg                     OUTPUT_GROUNDED,
    output reg  [`DCRP_CODE_W-1:0] INPUT_REG_VALUE,
    output reg  [`DCRP_CODE_W-1:0] OUTPUT_LATCH_VALUE
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    wire rst_pin_s;
    wire sclk_s;
    wire cs_n_s;
    wire din_s;
    wire load_output_n_n_s;
    wire pdn_s;
    wire fmt_s;
    wire lvl_s;
    wire gain_s;

    dcrp_sync #(
        .RST_VAL  (1'b0)
    ) u_rst (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (RESET_N_PIN),
        .sync_ff  (rst_pin_s)
    ); // see [R19]

    dcrp_sync #(
        .RST_VAL  (1'b0)
    ) u_sclk (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (SCLK_PIN),
        .sync_ff  (sclk_s)
    );

    dcrp_sync #(
        .RST_VAL  (1'b1)
    ) u_cs (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (CS_N_PIN),
        .sync_ff  (cs_n_s)
    );

    dcrp_sync #(
        .RST_VAL  (1'b0)
    ) u_din (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (DIN_PIN),
        .sync_ff  (din_s)
    );

    dcrp_sync #(
        .RST_VAL  (1'b1)
    ) u_load_output_n (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (LOAD_OUTPUT_N),
        .sync_ff  (load_output_n_n_s)
    );

    dcrp_sync #(
        .RST_VAL  (1'b0)
    ) u_pdn (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (POWER_DOWN_PIN),
        .sync_ff  (pdn_s)
    );

    dcrp_sync #(
        .RST_VAL  (1'b1)
    ) u_fmt (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (CODE_FORMAT_SELECT),
        .sync_ff  (fmt_s)
    );

    dcrp_sync #(
        .RST_VAL  (1'b0)
    ) u_lvl (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (RESET_LEVEL_SELECT),
        .sync_ff  (lvl_s)
    );

    dcrp_sync #(
        .RST_VAL  (1'b0)
    ) u_gain (
        .core_clk (CORE_CLK),
        .arst_n   (ARST_N),
        .async_in (GAIN_SELECT),
        .sync_ff  (gain_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function [`DCRP_CODE_W-1:0] reset_code;
        input level;
        begin
            reset_code = level ? `DCRP_MID_CODE : `DCRP_ZERO_CODE; // see [R9]
        end
    endfunction

    function [`DCRP_CODE_W-1:0] to_offset_binary;
        input [`DCRP_CODE_W-1:0] code;
        input                    straight;
        begin
            // see [R2] see [R3] see [R18]
            to_offset_binary = straight ? code
                : {~code[`DCRP_MSB], code[`DCRP_MSB-1:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // edge detection on synced serial pins
    reg sclk_d_ff;
    reg cs_n_d_ff;
    reg init_ff;
    reg rst_hold_ff;

    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire cs_rise   = cs_n_s & ~cs_n_d_ff;
    // one extra edge of reset: the strap settles on the same edge as the reset
    // pin, so without it reset would end before the strap is read
    wire in_reset  = ~rst_pin_s | rst_hold_ff | init_ff;

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sclk_d_ff   <= 1'b0;
            cs_n_d_ff   <= 1'b1;
            init_ff     <= 1'b1;
            rst_hold_ff <= 1'b1;
        end else begin
            sclk_d_ff   <= sclk_s;
            cs_n_d_ff   <= cs_n_s;
            init_ff     <= 1'b0; // reset state on first edge after release, see [R8]
            rst_hold_ff <= ~rst_pin_s; // see [R6] see [R19]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register and bit counter
    reg [`DCRP_CODE_W-1:0] shift_ff;
    reg [`DCRP_CNT_W-1:0]  cnt_ff;
    reg [`DCRP_CODE_W-1:0] nxt_shift;
    reg [`DCRP_CNT_W-1:0]  nxt_cnt;

    always @* begin
        nxt_shift = shift_ff;
        nxt_cnt   = cnt_ff;
        if (cs_n_s) begin
            nxt_cnt = {`DCRP_CNT_W{1'b0}};
        end else if (sclk_rise) begin
            // keeps working in power-down, see [R13]
            nxt_shift = {shift_ff[`DCRP_CODE_W-2:0], din_s}; // see [R1] see [R14]
            if (cnt_ff != `DCRP_FRAME_BITS) begin
                nxt_cnt = cnt_ff + 5'h01;
            end
        end
    end

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            shift_ff <= `DCRP_ZERO_CODE;
            cnt_ff   <= {`DCRP_CNT_W{1'b0}};
        end else begin
            shift_ff <= nxt_shift;
            cnt_ff   <= nxt_cnt;
        end
    end

    wire frame_ok = cs_rise & (cnt_ff == `DCRP_FRAME_BITS); // see [R15]

    ////////////////////////////////////////////////////////////////////////
    // input register and output latch
    reg [`DCRP_CODE_W-1:0] inreg_ff;
    reg [`DCRP_CODE_W-1:0] latch_ff;
    reg [`DCRP_CODE_W-1:0] nxt_inreg;
    reg [`DCRP_CODE_W-1:0] nxt_latch;

    always @* begin
        nxt_inreg = inreg_ff;
        nxt_latch = latch_ff;
        if (in_reset) begin
            nxt_inreg = reset_code(lvl_s); // see [R6] see [R8]
            nxt_latch = reset_code(lvl_s);
        end else begin
            // see [R7]; power-down does not touch either, see [R12]
            if (frame_ok) begin
                nxt_inreg = shift_ff; // see [R16]
            end
            if (!load_output_n_n_s) begin
                nxt_latch = nxt_inreg; // see [R17]
            end
        end
    end

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            inreg_ff <= `DCRP_ZERO_CODE;
            latch_ff <= `DCRP_ZERO_CODE;
        end else begin
            inreg_ff <= nxt_inreg;
            latch_ff <= nxt_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset code drives the converter as is until a written code is latched
    reg code_written_ff;
    reg show_raw_ff;
    reg nxt_code_written;
    reg nxt_show_raw;

    always @* begin
        nxt_code_written = code_written_ff;
        nxt_show_raw     = show_raw_ff;
        if (in_reset) begin
            nxt_code_written = 1'b0;
            nxt_show_raw     = 1'b1; // see [R8] see [R9]
        end else begin
            if (frame_ok) begin
                nxt_code_written = 1'b1;
            end
            // host keeps the strobe high until a write, see [R10]
            if (!load_output_n_n_s && nxt_code_written) begin
                nxt_show_raw = 1'b0;
            end
        end
    end

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            code_written_ff <= 1'b0;
            show_raw_ff     <= 1'b1;
        end else begin
            code_written_ff <= nxt_code_written;
            show_raw_ff     <= nxt_show_raw;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // reset value stays midscale or zero-scale in either format
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CONV_CODE          <= `DCRP_ZERO_CODE;
            BUFFER_GAIN        <= `DCRP_GAIN_ONE;
            OUTPUT_GROUNDED    <= 1'b0;
            INPUT_REG_VALUE    <= `DCRP_ZERO_CODE;
            OUTPUT_LATCH_VALUE <= `DCRP_ZERO_CODE;
        end else begin
            CONV_CODE          <= in_reset ? reset_code(lvl_s) // see [R4] see [R8]
                                  : to_offset_binary(latch_ff, fmt_s | show_raw_ff);
            BUFFER_GAIN        <= gain_s ? `DCRP_GAIN_TWO : `DCRP_GAIN_ONE; // see [R5]
            OUTPUT_GROUNDED    <= pdn_s; // see [R11]
            INPUT_REG_VALUE    <= inreg_ff;
            OUTPUT_LATCH_VALUE <= latch_ff;
        end
    end

endmodule // dcrp_core

/* dcrp_core_assertions.sv */
// Purpose: port checks for the converter core
// Assumes: pins and straps held steady several clocks
// Notes: bound below to the core
`timescale 1ns/1ps
module dcrp_core_assertions (
    input logic        CORE_CLK,
    input logic        ARST_N,
    input logic        RESET_N_PIN,
    input logic        CS_N_PIN,
    input logic        LOAD_OUTPUT_N,
    input logic        POWER_DOWN_PIN,
    input logic        CODE_FORMAT_SELECT,
    input logic        RESET_LEVEL_SELECT,
    input logic        GAIN_SELECT,
    input logic [15:0] CONV_CODE,
    input logic [1:0]  BUFFER_GAIN,
    input logic        OUTPUT_GROUNDED,
    input logic [15:0] INPUT_REG_VALUE,
    input logic [15:0] OUTPUT_LATCH_VALUE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    gain_one_a: assert property (!GAIN_SELECT[*5] |-> BUFFER_GAIN == 2'h1)
        else $error("gain not one");
    gain_two_a: assert property (GAIN_SELECT[*5] |-> BUFFER_GAIN == 2'h2)
        else $error("gain not two");
    pd_ground_a: assert property ($stable(POWER_DOWN_PIN)[*4] |->
        OUTPUT_GROUNDED == POWER_DOWN_PIN) else $error("ground state wrong");
    reset_hold_a: assert property (!RESET_N_PIN[*6] |->
        INPUT_REG_VALUE == {RESET_LEVEL_SELECT, 15'h0000}
        && OUTPUT_LATCH_VALUE == INPUT_REG_VALUE) else $error("reset value not held");
    straight_code_a: assert property (
        (CODE_FORMAT_SELECT && RESET_N_PIN)[*5] |->
        CONV_CODE == OUTPUT_LATCH_VALUE) else $error("straight code altered");
    latch_hold_a: assert property ((LOAD_OUTPUT_N && RESET_N_PIN)[*8] |=>
        $stable(OUTPUT_LATCH_VALUE)) else $error("latch moved while held");
    latch_follow_a: assert property ((!LOAD_OUTPUT_N && RESET_N_PIN)[*6] |->
        OUTPUT_LATCH_VALUE == INPUT_REG_VALUE) else $error("latch not transparent");
    inreg_keep_a: assert property ((CS_N_PIN && RESET_N_PIN)[*8] |=>
        $stable(INPUT_REG_VALUE)) else $error("input register moved");
    code_low_a: assert property (RESET_N_PIN[*5] |->
        CONV_CODE[14:0] == OUTPUT_LATCH_VALUE[14:0]) else $error("code low bits altered");
endmodule // dcrp_core_assertions
bind dcrp_core dcrp_core_assertions u_chk (.*);

/* dcrp_host_model.sv */
// Purpose: host serial controller writing codes
// Assumes: data taken on the rising serial clock
// Notes: clock idles low; data shows its inverse between frames
`timescale 1ns/1ps
module dcrp_host_model (
    output logic SCLK_PIN,
    output logic CS_N_PIN,
    output logic DIN_PIN
);
    initial {SCLK_PIN, CS_N_PIN, DIN_PIN} = 3'h2;
    // msb first; offset keeps serial edges off the core clock edges
    task automatic send(logic [31:0] word, int nbits);
        #13 CS_N_PIN = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            DIN_PIN = word[i];
            #160 SCLK_PIN = 1'b1;
            #160 SCLK_PIN = 1'b0;
        end
        #160 CS_N_PIN = 1'b1;
        DIN_PIN = ~DIN_PIN;
        #400;
    endtask
endmodule // dcrp_host_model

/* dcrp_core_tb.sv */
// Purpose: self-checking bench for the converter core
// Assumes: host model sends 320 ns serial bits
// Notes: fixed seed; corner codes first, then random
`timescale 1ns/1ps
module dcrp_core_tb;
    logic        CORE_CLK, ARST_N, RESET_N_PIN, SCLK_PIN, CS_N_PIN, DIN_PIN, LOAD_OUTPUT_N;
    logic        POWER_DOWN_PIN, CODE_FORMAT_SELECT, RESET_LEVEL_SELECT, GAIN_SELECT;
    logic        OUTPUT_GROUNDED;
    logic [1:0]  BUFFER_GAIN;
    logic [15:0] CONV_CODE, INPUT_REG_VALUE, OUTPUT_LATCH_VALUE, code, prev;
    int          n_fail = 0;
    int          tests_run = 0;
    dcrp_core u_dcrp_core (.*);
    dcrp_host_model u_dcrp_host_model (.*);
    initial begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    task automatic cyc(int n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] conv(logic [15:0] c, logic straight);
        return straight ? c : {~c[15], c[14:0]};
    endfunction
    function automatic logic [15:0] rst_val(logic lvl);
        return {lvl, 15'h0000};
    endfunction
    task end_sim;
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        n_fail++;
        end_sim;
    end
    initial begin
        {ARST_N, RESET_N_PIN, LOAD_OUTPUT_N, POWER_DOWN_PIN} = 4'h6;
        {CODE_FORMAT_SELECT, RESET_LEVEL_SELECT, GAIN_SELECT} = 3'h6;
        code = $urandom(32'hF43358B5);
        cyc(16);
        ARST_N <= 1'b1;
        cyc(10);
        chk(OUTPUT_LATCH_VALUE, 16'h8000);
        chk(CONV_CODE, 16'h8000);
        for (int k = 0; k < 4; k++) begin
            {RESET_N_PIN, RESET_LEVEL_SELECT, CODE_FORMAT_SELECT} <= {1'b0, k[1:0]};
            cyc(8);
            chk(CONV_CODE, rst_val(k[1]));
            chk(OUTPUT_LATCH_VALUE, rst_val(k[1]));
            RESET_N_PIN <= 1'b1;
            cyc(8);
            chk(INPUT_REG_VALUE, rst_val(k[1]));
            chk(CONV_CODE, rst_val(k[1]));
        end
        prev = 16'h8000;
        for (int k = 0; k < 12; k++) begin
            code = k < 8 ? {k[0], {15{k[1]}}} : 16'($urandom);
            {CODE_FORMAT_SELECT, GAIN_SELECT, POWER_DOWN_PIN} <= {~k[2], 2'($urandom)};
            u_dcrp_host_model.send({16'($urandom), code}, 16 + k % 3);
            cyc(6);
            chk(INPUT_REG_VALUE, code);
            chk(OUTPUT_LATCH_VALUE, prev);
            LOAD_OUTPUT_N <= 1'b0;
            cyc(8);
            chk(OUTPUT_LATCH_VALUE, code);
            chk(CONV_CODE, conv(code, CODE_FORMAT_SELECT));
            chk({15'h0000, OUTPUT_GROUNDED}, {15'h0000, POWER_DOWN_PIN});
            chk({14'h0000, BUFFER_GAIN}, {14'h0000, GAIN_SELECT, ~GAIN_SELECT});
            LOAD_OUTPUT_N <= 1'b1;
            prev = code;
        end
        u_dcrp_host_model.send({17'h00000, ~code[14:0]}, 15);
        cyc(6);
        chk(INPUT_REG_VALUE, prev);
        chk(OUTPUT_LATCH_VALUE, prev);
        end_sim;
    end
endmodule // dcrp_core_tb
